// ### rtl/cidc_top.sv
// Converter control: startup sequencing, result correction, event flags,
// interrupt gating, and a buffer writer fed through a small FIFO.
// Assumes the converter macro and the memory port share sys_clk_in.
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Result FIFO
// ------------------------------------------------------------------
module cidc_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic flush_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0] count_q;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count
  assign in_ready_out = (count_q != DEPTH[PW:0]);
  assign out_valid_out = (count_q != '0);
  assign out_data_out = mem_q[rd_ptr_q];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Storage has no reset; only pointers and count need a defined value
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end

  // Pointers and count; flush drops everything held
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else if (flush_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule : cidc_fifo

// Functional notes
// - One interrupt line, enabled by a set strobe, disabled by a clear strobe.
// - Overflow flag sets when a result is ready while the buffer writer is off.
// - Saturation flag sets when the gain product leaves the signed 16-bit range.
// - Buffer-full flag sets on a write to the last buffer location.
// - Buffer-half flag sets on a write to the last first-half location.
// - Data-ready flag sets when a new result lands in the data register.
// - Writing one clears a flag; writing zero leaves it alone.
// - Interrupt asserts only for set flags whose mask bit is one.
// - While enabled, conversions run back to back until disabled.
// - A fresh enable waits a 21 us hardware startup delay first.
// - First conversion after enable or configuration write is discarded.
// - A system clock source switch also discards the next conversion.
// - Fresh enable latency is startup delay plus two sample times.
// - A configuration write does not stop the buffer writer.
// - Sample timing does not depend on which oscillator clocks the system.
// - Buffer is begin address plus size in samples; reset bit reinitializes.
// - Wrap plus start together run the writer, returning to buffer start.
// - Results are 16-bit two's complement in register and buffer.
// - Gain is unsigned 16-bit in 1/32768 steps, default 32768.
// - Offset is a signed 16-bit value added to the result.
module cidc_top (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Converter configuration
  input wire logic adc_enable_in,
  input wire logic cfg_write_in,
  input wire logic clk_switch_in,
  input wire logic gain_write_in,
  input wire logic [15:0] gain_value_in,
  input wire logic offset_write_in,
  input wire logic [15:0] offset_value_in,
  // Analog converter
  input wire logic conv_done_in,
  input wire logic [15:0] conv_data_in,
  output logic conv_run_out,
  output logic conv_restart_out,
  // Result register
  output logic [15:0] result_data_out,
  // Event flags and interrupt
  input wire logic [4:0] event_flag_clear_in,
  input wire logic [4:0] event_mask_in,
  input wire logic irq_set_enable_in,
  input wire logic irq_clear_enable_in,
  output logic [4:0] event_flag_out,
  output logic irq_out,
  // Buffer writer configuration
  input wire logic dma_reset_in,
  input wire logic dma_start_in,
  input wire logic dma_wrap_mode_in,
  input wire logic [31:0] dma_begin_addr_in,
  input wire logic [15:0] dma_buffer_size_in,
  output logic dma_active_out,
  // Memory write port
  output logic dma_wr_valid_out,
  input wire logic dma_wr_ready_in,
  output logic [31:0] dma_wr_addr_out,
  output logic [15:0] dma_wr_data_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // True when an 18-bit value does not fit a signed 16-bit result
  function automatic logic out_of_range(input logic [17:0] v);
    out_of_range = !((v[17:15] == 3'b000) || (v[17:15] == 3'b111));
  endfunction : out_of_range

  // Clamp an 18-bit value into the signed 16-bit range
  function automatic logic [15:0] clamp16(input logic [17:0] v);
    if (!out_of_range(v)) begin
      clamp16 = v[15:0];
    end else if (v[17]) begin
      clamp16 = 16'h8000;
    end else begin
      clamp16 = 16'h7FFF;
    end
  endfunction : clamp16

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cidc_pkg::cidc_state_t state_q;
  logic [cidc_pkg::STARTUP_CNT_W-1:0] startup_cnt_q;
  logic restart_q;
  logic [15:0] gain_q;
  logic [15:0] offset_q;
  logic [15:0] result_q;
  logic [4:0] flag_q;
  logic [4:0] flag_set;
  logic irq_en_q;
  logic irq_q;
  logic dma_active_q;
  logic [15:0] dma_idx_q;
  logic conv_keep;
  logic signed [32:0] product;
  logic [32:0] scaled;
  logic [17:0] sum;
  logic prod_sat;
  logic [15:0] prod_clamped;
  logic sum_sat;
  logic [15:0] corrected;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [15:0] fifo_out_data;
  logic wr_done;
  logic at_last;
  logic at_half;

  // ----------------------------------------------------------------
  // Converter sequencing
  // ----------------------------------------------------------------
  // Sequencing counts system clocks at a fixed rate, so the startup
  // delay is the same whichever oscillator feeds the clock tree
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= cidc_pkg::CIDC_ST_IDLE;
      startup_cnt_q <= '0;
      restart_q <= 1'b0;
    end else begin
      restart_q <= 1'b0;
      case (state_q)
        cidc_pkg::CIDC_ST_IDLE: begin
          if (adc_enable_in) begin
            state_q <= cidc_pkg::CIDC_ST_STARTUP;
            startup_cnt_q <= '0;
          end
        end
        cidc_pkg::CIDC_ST_STARTUP: begin
          if (!adc_enable_in) begin
            state_q <= cidc_pkg::CIDC_ST_IDLE;
          end else if (startup_cnt_q ==
              cidc_pkg::STARTUP_CNT_W'(cidc_pkg::STARTUP_CYC - 1)) begin
            state_q <= cidc_pkg::CIDC_ST_DISCARD;
            restart_q <= 1'b1;
          end else begin
            startup_cnt_q <= startup_cnt_q + 1'b1;
          end
        end
        cidc_pkg::CIDC_ST_DISCARD: begin
          if (!adc_enable_in) begin
            state_q <= cidc_pkg::CIDC_ST_IDLE;
          end else if (cfg_write_in || clk_switch_in) begin
            restart_q <= 1'b1;
          end else if (conv_done_in) begin
            state_q <= cidc_pkg::CIDC_ST_RUN;
          end
        end
        cidc_pkg::CIDC_ST_RUN: begin
          if (!adc_enable_in) begin
            state_q <= cidc_pkg::CIDC_ST_IDLE;
          end else if (cfg_write_in || clk_switch_in) begin
            state_q <= cidc_pkg::CIDC_ST_DISCARD;
            restart_q <= 1'b1;
          end
        end
        default: begin
          state_q <= cidc_pkg::CIDC_ST_IDLE;
        end
      endcase
    end
  end

  // Converter runs continuously in discard and run states
  assign conv_run_out = (state_q == cidc_pkg::CIDC_ST_DISCARD) ||
                        (state_q == cidc_pkg::CIDC_ST_RUN);
  assign conv_restart_out = restart_q;
  // A result arriving with a configuration change is from the old setup
  assign conv_keep = conv_done_in &&
                     (state_q == cidc_pkg::CIDC_ST_RUN) &&
                     !cfg_write_in && !clk_switch_in;

  // ----------------------------------------------------------------
  // Correction
  // ----------------------------------------------------------------
  // Gain and offset registers
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gain_q <= cidc_pkg::GAIN_RESET;
      offset_q <= cidc_pkg::OFFSET_RESET;
    end else begin
      if (gain_write_in) begin
        gain_q <= gain_value_in;
      end
      if (offset_write_in) begin
        offset_q <= offset_value_in;
      end
    end
  end

  // Gain is zero-extended so a factor near two stays positive
  assign product = $signed(conv_data_in) * $signed({1'b0, gain_q});
  assign scaled = product >>> cidc_pkg::GAIN_SHIFT;
  assign prod_sat = out_of_range(scaled[17:0]);
  // Offset applies to the clamped product, as calibration expects
  assign prod_clamped = clamp16(scaled[17:0]);
  assign sum = {{2{prod_clamped[15]}}, prod_clamped} +
               {{2{offset_q[15]}}, offset_q};
  assign sum_sat = out_of_range(sum);
  assign corrected = clamp16(sum);

  // Result data register
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result_q <= '0;
    end else if (conv_keep) begin
      result_q <= corrected;
    end
  end

  assign result_data_out = result_q;

  // ----------------------------------------------------------------
  // Buffer writer
  // ----------------------------------------------------------------
  assign wr_done = fifo_out_valid && dma_wr_ready_in;
  // A size of zero is treated like one so the index cannot run away
  assign at_last = (dma_buffer_size_in == '0) ||
                   (dma_idx_q == dma_buffer_size_in - 16'h0001);
  assign at_half = (dma_buffer_size_in > 16'h0001) &&
                   (dma_idx_q == (dma_buffer_size_in >> 1) - 16'h0001);

  // Writer state; configuration writes do not touch it
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dma_active_q <= 1'b0;
      dma_idx_q <= '0;
    end else if (dma_reset_in) begin
      dma_active_q <= 1'b0;
      dma_idx_q <= '0;
    end else begin
      if (dma_start_in && dma_wrap_mode_in) begin
        dma_active_q <= 1'b1;
      end
      if (wr_done) begin
        if (at_last) begin
          dma_idx_q <= '0;
        end else begin
          dma_idx_q <= dma_idx_q + 16'h0001;
        end
      end
    end
  end

  assign dma_active_out = dma_active_q;

  // Results queue here so a slow memory port does not drop samples
  cidc_fifo #(
    .WIDTH(cidc_pkg::SAMPLE_W),
    .DEPTH(cidc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .flush_in(dma_reset_in),
    .in_valid_in(conv_keep && dma_active_q),
    .in_ready_out(fifo_in_ready),
    .in_data_in(corrected),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(dma_wr_ready_in),
    .out_data_out(fifo_out_data)
  );

  // Half-word addressing; bit zero is forced low for alignment
  assign dma_wr_valid_out = fifo_out_valid;
  assign dma_wr_addr_out = {dma_begin_addr_in[31:1], 1'b0} +
                           {15'h0000, dma_idx_q, 1'b0};
  assign dma_wr_data_out = fifo_out_data;

  // ----------------------------------------------------------------
  // Event flags and interrupt
  // ----------------------------------------------------------------
  // A result with nowhere to go, writer off or queue full, is overflow
  always_comb begin
    flag_set = '0;
    flag_set[cidc_pkg::FLAG_OVERFLOW] =
      conv_keep && (!dma_active_q || !fifo_in_ready);
    flag_set[cidc_pkg::FLAG_SATURATION] =
      conv_keep && (prod_sat || sum_sat);
    flag_set[cidc_pkg::FLAG_BUFFER_FULL] = wr_done && at_last;
    flag_set[cidc_pkg::FLAG_BUFFER_HALF] = wr_done && at_half;
    flag_set[cidc_pkg::FLAG_DATA_READY] = conv_keep;
  end

  // Sticky flags; a set in the clearing cycle wins over the clear
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~event_flag_clear_in) | flag_set;
    end
  end

  assign event_flag_out = flag_q;

  // Top-level enable; set strobe wins if both arrive together
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_en_q <= 1'b0;
    end else if (irq_set_enable_in) begin
      irq_en_q <= 1'b1;
    end else if (irq_clear_enable_in) begin
      irq_en_q <= 1'b0;
    end
  end

  // Masked flags stay set but do not reach the line
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_en_q && |(flag_q & event_mask_in);
    end
  end

  assign irq_out = irq_q;

endmodule : cidc_top
`default_nettype wire

// ### shared/cidc_pkg.sv
// Shared constants and types for the converter control block.
// Assumes one 100 MHz system clock; all control bits arrive as plain ports.
package cidc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned SIZE_W = 16;
  localparam int unsigned FLAG_W = 5;
  localparam int unsigned FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // Event flag positions
  // ----------------------------------------------------------------
  localparam int unsigned FLAG_OVERFLOW = 0;
  localparam int unsigned FLAG_SATURATION = 1;
  localparam int unsigned FLAG_BUFFER_FULL = 2;
  localparam int unsigned FLAG_BUFFER_HALF = 3;
  localparam int unsigned FLAG_DATA_READY = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] GAIN_RESET = 16'h8000;   // Unity gain
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam int unsigned GAIN_SHIFT = 15;         // Gain step is 1/32768

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned STARTUP_NS = 21000;
  localparam int unsigned STARTUP_CYC =
    (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STARTUP_CNT_W = 12;

  // ----------------------------------------------------------------
  // Converter sequencing states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CIDC_ST_IDLE = 4'h1,
    CIDC_ST_STARTUP = 4'h2,
    CIDC_ST_DISCARD = 4'h4,
    CIDC_ST_RUN = 4'h8
  } cidc_state_t;

endpackage : cidc_pkg

// ### bench/cidc_asserts.sv
// Port-level checks for the converter control top module.
// Assumes one clock domain and binding into every cidc_top instance.
`timescale 1ns/1ps
`default_nettype none
module cidc_asserts (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // Controls and strobes
  input wire logic adc_enable_in, cfg_write_in, clk_switch_in,
  input wire logic conv_done_in, irq_set_enable_in, irq_clear_enable_in,
  input wire logic dma_reset_in, dma_start_in, dma_wrap_mode_in,
  input wire logic dma_wr_ready_in,
  input wire logic [4:0] event_flag_clear_in,
  input wire logic [4:0] event_mask_in,
  // Observed outputs
  input wire logic conv_run_out, conv_restart_out, irq_out,
  input wire logic dma_active_out, dma_wr_valid_out,
  input wire logic [15:0] result_data_out,
  input wire logic [15:0] dma_wr_data_out,
  input wire logic [4:0] event_flag_out,
  input wire logic [31:0] dma_wr_addr_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  AST_IDLE: assert property (!adc_enable_in |=> !conv_run_out)
    else $error("converter still running after disable");
  AST_STARTUP: assert property (
    $rose(adc_enable_in) |=> (!conv_run_out) [*8])
    else $error("converter ran inside the startup delay");
  AST_RESTART: assert property (
    (cfg_write_in || clk_switch_in) && conv_run_out && adc_enable_in
    |=> conv_restart_out) else $error("no restart after change");

  // ----------------------------------------------------------------
  // Results, flags and interrupt
  // ----------------------------------------------------------------
  AST_DATA_READY: assert property (
    $rose(event_flag_out[4]) |-> $past(conv_done_in))
    else $error("data flag rose without a result");
  AST_RESULT: assert property (
    !$stable(result_data_out) |-> $past(conv_done_in))
    else $error("result moved without a result");
  AST_OVERFLOW: assert property (
    $rose(event_flag_out[4]) && !$past(dma_active_out)
    |-> event_flag_out[0]) else $error("overflow missed");
  AST_CLEAR: assert property (
    event_flag_clear_in[1] && !conv_done_in |=> !event_flag_out[1])
    else $error("saturation flag not cleared");
  AST_STICKY: assert property (
    event_flag_out[4] && !event_flag_clear_in[4] |=> event_flag_out[4])
    else $error("data flag lost without clear");
  AST_IRQ_MASK: assert property (
    irq_out |-> |($past(event_flag_out) & $past(event_mask_in)))
    else $error("interrupt without unmasked flag");
  AST_IRQ_OFF: assert property (
    irq_clear_enable_in && !irq_set_enable_in ##1 !irq_set_enable_in
    |=> !irq_out) else $error("interrupt after disable");

  // ----------------------------------------------------------------
  // Buffer writer
  // ----------------------------------------------------------------
  AST_DMA_START: assert property (
    dma_start_in && dma_wrap_mode_in && !dma_reset_in |=> dma_active_out)
    else $error("writer did not start");
  AST_WR_HOLD: assert property (
    dma_wr_valid_out && !dma_wr_ready_in && !dma_reset_in
    |=> dma_wr_valid_out && $stable(dma_wr_addr_out)
    && $stable(dma_wr_data_out)) else $error("write dropped in stall");
  AST_ALIGN: assert property (dma_wr_valid_out |-> !dma_wr_addr_out[0])
    else $error("write address odd");
endmodule : cidc_asserts

bind cidc_top cidc_asserts i_cidc_asserts (.*);
`default_nettype wire

// ### bench/cidc_conv_model.sv
// Partner model: converter pacing results, memory taking buffer writes.
// Assumes the bench clock; writes are logged for the bench to read.
`timescale 1ns/1ps
`default_nettype none
module cidc_conv_model #(
  parameter int SAMPLE_CYC = 20
) (
  // Clock, reset and bench controls
  input wire logic clk_in, rst_n_in, pause_in, stall_in,
  input wire logic [15:0] raw_in,
  // Converter side
  input wire logic run_in, restart_in,
  output logic done_out,
  output logic [15:0] data_out,
  // Memory side
  input wire logic wr_valid_in,
  input wire logic [31:0] wr_addr_in,
  input wire logic [15:0] wr_data_in,
  output logic wr_ready_out
);
  int cnt;
  int wr_count;
  logic pause_q;
  logic [31:0] addr_log [$];
  logic [15:0] data_log [$];
  initial done_out = 1'b0;
  initial wr_ready_out = 1'b0;
  // Pacing counts cycles only, so clock source never alters it
  always @(negedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in || !run_in || restart_in) begin
      cnt <= 0;
      done_out <= 1'b0;
    end else begin
      cnt <= (cnt == SAMPLE_CYC - 1) ? 0 : cnt + 1;
      done_out <= (cnt == SAMPLE_CYC - 1) && !pause_q;
    end
  end
  // Data is meaningless outside done, so show the inverse there
  assign data_out = done_out ? raw_in : ~raw_in;
  // Memory accepts half-word writes unless told to stall
  always @(posedge clk_in) begin
    wr_ready_out <= !stall_in;
    pause_q <= pause_in; // Taken here so falling-edge writes never race
    if (wr_valid_in && wr_ready_out) begin
      addr_log.push_back(wr_addr_in);
      data_log.push_back(wr_data_in);
      wr_count <= wr_count + 1;
    end
  end
endmodule : cidc_conv_model
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench: startup, correction, flags, interrupt, writer.
// Assumes the partner model stands on the converter and memory ports.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int S = 20;
  logic sys_clk_in, rst_n_in, adc_enable_in, cfg_write_in, clk_switch_in;
  logic gain_write_in, offset_write_in, conv_done_in, conv_run_out;
  logic conv_restart_out, irq_set_enable_in, irq_clear_enable_in, irq_out;
  logic dma_reset_in, dma_start_in, dma_wrap_mode_in, dma_active_out;
  logic dma_wr_valid_out, dma_wr_ready_in, pause, stall;
  logic [15:0] gain_value_in, offset_value_in, conv_data_in, raw;
  logic [15:0] result_data_out, dma_buffer_size_in, dma_wr_data_out;
  logic [4:0] event_flag_clear_in, event_mask_in, event_flag_out;
  logic [31:0] dma_begin_addr_in, dma_wr_addr_out;
  int failures, checked, cycles;

  cidc_top i_cidc_top (.*);
  cidc_conv_model #(.SAMPLE_CYC(S)) i_cidc_conv_model (
    .clk_in(sys_clk_in), .rst_n_in(rst_n_in), .pause_in(pause),
    .stall_in(stall), .raw_in(raw), .run_in(conv_run_out),
    .restart_in(conv_restart_out), .done_out(conv_done_in),
    .data_out(conv_data_in), .wr_valid_in(dma_wr_valid_out),
    .wr_addr_in(dma_wr_addr_out), .wr_data_in(dma_wr_data_out),
    .wr_ready_out(dma_wr_ready_in));

  // Clock and a hang limit well above the roughly 3000 cycles needed
  always #5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tick(int n);
    repeat (n) @(negedge sys_clk_in);
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse
  // Clear some flags, then wait until the data-ready flag is set
  task automatic next_result(logic [4:0] v);
    int n;
    n = 0;
    event_flag_clear_in = v;
    tick(1);
    event_flag_clear_in = 5'h00;
    do begin
      tick(1);
      n++;
    end while (event_flag_out[4] !== 1'b1 && n < 200);
  endtask : next_result
  task automatic wait_writes(int k);
    int n;
    n = 0;
    while (i_cidc_conv_model.wr_count < k && n < 1000) begin
      tick(1);
      n++;
    end
  endtask : wait_writes
  task automatic finish_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_startup();
    int n;
    logic early;
    n = 0;
    early = 1'b0;
    adc_enable_in = 1'b1;
    while (conv_restart_out !== 1'b1 && n < 3000) begin
      early = early | conv_run_out;
      tick(1);
      n++;
    end
    check("early run", early, 0);
    check("delay", n >= cidc_pkg::STARTUP_CYC &&
      n <= cidc_pkg::STARTUP_CYC + 2, 1);
    n = 0;
    while (event_flag_out[4] !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    check("discard", n >= 2 * S && n <= 2 * S + 3, 1);
    check("unity", result_data_out, 16'h1234);
    check("flags", event_flag_out, 5'h11);
    $display("startup done");
  endtask : test_startup

  task automatic test_correction();
    // Sat bit, raw, gain, offset, expected result
    logic [64:0] t [5] = '{65'h0_1000_4000_0010_0810,
      65'h1_7000_FFFF_0000_7FFF, 65'h1_8000_FFFF_0000_8000,
      65'h1_7FFF_8000_0001_7FFF, 65'h0_F000_8000_FFF0_EFF0};
    for (int i = 0; i < 6; i++) begin
      {raw, gain_value_in, offset_value_in} = (i < 5) ? t[i][63:16] :
        48'h1234_8000_0000;
      pulse(gain_write_in);
      pulse(offset_write_in);
      next_result(5'h10);
      next_result(5'h12);
      if (i < 5) begin
        check("result", result_data_out, t[i][15:0]);
        check("sat", event_flag_out[1], t[i][64]);
      end
    end
    $display("correction done");
  endtask : test_correction

  task automatic test_flags();
    pause = 1'b1;
    tick(3);
    event_mask_in = 5'h00;
    pulse(irq_set_enable_in);
    event_flag_clear_in = 5'h0E;
    tick(3);
    check("masked", irq_out, 0);
    check("zero write", event_flag_out, 5'h11);
    event_flag_clear_in = 5'h00;
    event_mask_in = 5'h10;
    tick(3);
    check("unmasked", irq_out, 1);
    pulse(irq_clear_enable_in);
    tick(3);
    check("disabled", irq_out, 0);
    pulse(irq_set_enable_in);
    tick(3);
    check("enabled", irq_out, 1);
    event_flag_clear_in = 5'h10;
    tick(1);
    event_flag_clear_in = 5'h00;
    tick(2);
    check("cleared", event_flag_out, 5'h01);
    check("irq gone", irq_out, 0);
    event_mask_in = 5'h00;
    pause = 1'b0;
    clk_switch_in = 1'b1;
    tick(1);
    check("switch", conv_restart_out, 1);
    clk_switch_in = 1'b0;
    $display("flags done");
  endtask : test_flags

  task automatic test_dma();
    dma_begin_addr_in = 32'h0000_1001;
    dma_buffer_size_in = 16'h0004;
    dma_wrap_mode_in = 1'b1;
    pulse(dma_reset_in);
    pulse(dma_start_in);
    check("active", dma_active_out, 1);
    next_result(5'h0D);
    wait_writes(2);
    tick(2);
    check("half", event_flag_out[3:2], 2'b10);
    stall = 1'b1;
    tick(3 * S);
    stall = 1'b0;
    wait_writes(4);
    tick(2);
    check("full", event_flag_out[2], 1);
    cfg_write_in = 1'b1;
    tick(1);
    check("cfg restart", conv_restart_out, 1);
    cfg_write_in = 1'b0;
    wait_writes(7);
    check("kept on", dma_active_out, 1);
    for (int i = 0; i < 7; i++) begin
      check("addr", i_cidc_conv_model.addr_log[i],
        32'h1000 + 2 * (i % 4));
      check("data", i_cidc_conv_model.data_log[i], 16'h1234);
    end
    check("no ovf", event_flag_out[0], 0);
    $display("writer done");
  endtask : test_dma

  task automatic test_fifo();
    int n0;
    stall = 1'b1;
    tick(20 * S);
    check("refused", event_flag_out[0], 1);
    pause = 1'b1;
    tick(3);
    n0 = i_cidc_conv_model.wr_count;
    stall = 1'b0;
    tick(40);
    check("drained", i_cidc_conv_model.wr_count - n0, 16);
    check("empty", dma_wr_valid_out, 0);
    pulse(dma_reset_in);
    check("reset", dma_active_out, 0);
    adc_enable_in = 1'b0;
    tick(2);
    check("stopped", conv_run_out, 0);
    $display("fifo done");
  endtask : test_fifo

  // Main sequence: reset for eight cycles, then each scenario
  initial begin
    {sys_clk_in, rst_n_in, adc_enable_in, cfg_write_in, clk_switch_in} = '0;
    {gain_write_in, offset_write_in, irq_set_enable_in} = '0;
    {irq_clear_enable_in, dma_reset_in, dma_start_in, dma_wrap_mode_in} = '0;
    {gain_value_in, offset_value_in, dma_buffer_size_in} = '0;
    {event_flag_clear_in, event_mask_in, dma_begin_addr_in} = '0;
    {pause, stall, raw} = {2'b00, 16'h1234};
    tick(8);
    rst_n_in = 1'b1;
    tick(2);
    test_startup();
    test_correction();
    test_flags();
    test_dma();
    test_fifo();
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
